// ### src/iaq_top.sv
// Addressing and per-byte command queue of a two-wire bus controller.
// Assumes a byte engine on the same clock that executes one command at
// a time and pulses CMD_DONE; SCL is open drain and outside the domain.
// Notes on behaviour
// - Special bit set: bit 10 picks broadcast/startbyte
// - After broadcast, read command raises transmit abort
// - Broadcast mode lasts until special bit cleared or bit 10 set
// - Ten-bit target address, reset value 0x55
// - Broadcast ignores stored target address bits
// - Master never reads from itself; simplex loopback only
// - Own address 0x55; 7-bit mode compares 6:0
// - Own address writable only while controller disabled
// - Restart bit: restart, or stop+start if disabled
// - Direction change alone triggers restart or stop+start
// - Stop bit: stop, then start if queue nonempty
// - No stop, queue nonempty: continue transfer
// - No stop, queue empty: hold SCL low
// - Bit 8 is master direction, ignored as slave
// - Slave transmitter sends low byte of command
// - Special bit clear: address stored target normally
// - Restarts only when repeated-start permit set
// - Read after slave read request aborts, discarded
`timescale 1ns/1ps
`default_nettype none
module iaq_top (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Register port
   input wire logic [31:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   // Clock line of the bus
   input wire logic SCL_I,
   output logic SCL_O,
   output logic SCL_OE,
   // Command to the byte engine
   output logic CMD_VALID,
   output logic CMD_START,
   output logic CMD_RESTART,
   output logic CMD_STOP_START,
   output logic CMD_STOP,
   output logic CMD_READ,
   output logic CMD_GCALL,
   output logic CMD_SBYTE,
   output logic [9:0] CMD_TARGET,
   output logic [7:0] CMD_DATA,
   input wire logic CMD_DONE,
   // Slave side
   input wire logic [9:0] SLV_ADDR,
   output logic SLV_MATCH,
   input wire logic SLV_RD_REQ,
   input wire logic SLV_POP,
   input wire logic [7:0] RX_DATA
);
   logic [1:0] rst_ff;
   logic rst_n;
   logic scl_s;
   logic [6:0] con_ff, nxt_con;
   logic [11:0] tar_ff, nxt_tar;
   logic [9:0] sar_ff, nxt_sar;
   logic ena_ff, nxt_ena;
   logic abort_ff, nxt_abort;
   logic rdreq_ff, nxt_rdreq;
   logic [15:0] rdata_ff, nxt_rdata;
   logic match_ff;
   iaq_pkg::iaq_state_t st_ff, nxt_st;
   logic active_ff, nxt_active;
   logic dir_ff, nxt_dir;
   logic [iaq_pkg::CMD_W-1:0] cmd_ff, nxt_cmd;
   logic [4:0] flag_ff, nxt_flag;
   logic [iaq_pkg::CMD_W-1:0] q_out;
   logic q_valid, q_ready, q_in_ready, push;
   logic [iaq_pkg::FIFO_AW:0] q_level;
   logic master_en, slave_en, ren, gc_mode, cmd_wr, rd_cmd, bad_read;
   logic done, open_now, pop, turn;

   function automatic logic addr_eq(input logic [9:0] a,
                                    input logic [9:0] b,
                                    input logic ten);
      addr_eq = ten ? (a == b) : (a[6:0] == b[6:0]);
   endfunction : addr_eq

   // Reset is released through two flops so all logic leaves it together
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_ff <= 2'h0;
      end else begin
         rst_ff <= {rst_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_ff[1];

   iaq_sync u_scl_sync (
      .clk(CLK),
      .rst_n(rst_n),
      .d(SCL_I),
      .q(scl_s)
   );

   assign master_en = con_ff[iaq_pkg::CON_MASTER_BIT];
   assign slave_en = ~con_ff[iaq_pkg::CON_SLVDIS_BIT];
   assign ren = con_ff[iaq_pkg::CON_RESTART_BIT];
   // Mode is held by the special and select bits, so it ends when special is cleared or select is set
   assign gc_mode = tar_ff[iaq_pkg::TAR_SPECIAL_BIT]
                    & ~tar_ff[iaq_pkg::TAR_SEL_BIT];
   assign cmd_wr = WR && ADDR == iaq_pkg::CMD_ADDR;
   assign rd_cmd = WDATA[iaq_pkg::CMD_READ_BIT] & master_en;
   // A master read to its own slave address would need duplex loopback
   assign bad_read = rd_cmd & (gc_mode | rdreq_ff
                     | (slave_en & addr_eq(tar_ff[9:0], sar_ff,
                        con_ff[iaq_pkg::CON_TENS_BIT])));
   assign push = cmd_wr & ena_ff & ~bad_read;

   iaq_fifo u_queue (
      .clk(CLK),
      .rst_n(rst_n),
      .in_valid(push),
      .in_data({WDATA[10:9], rd_cmd, WDATA[7:0]}),
      .in_ready(q_in_ready),
      .out_valid(q_valid),
      .out_data(q_out),
      .out_ready(q_ready),
      .level(q_level)
   );

   // Registers and event flags
   always_comb begin
      nxt_con = con_ff;
      nxt_tar = tar_ff;
      nxt_sar = sar_ff;
      nxt_ena = ena_ff;
      nxt_abort = abort_ff;
      nxt_rdreq = rdreq_ff;
      nxt_rdata = 16'h0000;
      if (WR) begin
         unique case (ADDR)
            iaq_pkg::CON_ADDR: nxt_con = WDATA[6:0];
            iaq_pkg::TAR_ADDR: nxt_tar = WDATA[11:0];
            iaq_pkg::SAR_ADDR: begin
               if (!ena_ff) begin
                  nxt_sar = WDATA[9:0];
               end
            end
            iaq_pkg::ENA_ADDR: nxt_ena = WDATA[0];
            default: ;
         endcase
      end
      if (RD) begin
         unique case (ADDR)
            iaq_pkg::CON_ADDR: nxt_rdata = {9'h000, con_ff};
            iaq_pkg::TAR_ADDR: nxt_rdata = {4'h0, tar_ff};
            iaq_pkg::SAR_ADDR: nxt_rdata = {6'h00, sar_ff};
            iaq_pkg::CMD_ADDR: nxt_rdata = {8'h00, RX_DATA};
            iaq_pkg::RAW_ADDR: begin
               nxt_rdata[iaq_pkg::RAW_ABORT_BIT] = abort_ff;
               nxt_rdata[iaq_pkg::RAW_RDREQ_BIT] = rdreq_ff;
            end
            iaq_pkg::CLR_ABORT_ADDR: begin
               nxt_rdata = {15'h0000, abort_ff};
               nxt_abort = 1'b0;
            end
            iaq_pkg::CLR_RDREQ_ADDR: begin
               nxt_rdata = {15'h0000, rdreq_ff};
               nxt_rdreq = 1'b0;
            end
            iaq_pkg::ENA_ADDR: nxt_rdata = {15'h0000, ena_ff};
            iaq_pkg::STAT_ADDR: nxt_rdata = {10'h000, q_level, scl_s,
               st_ff == iaq_pkg::ST_STALL, active_ff};
            default: nxt_rdata = 16'h0000;
         endcase
      end
      // Set wins over a clear in the same cycle
      if (cmd_wr && bad_read) begin
         nxt_abort = 1'b1;
      end
      if (SLV_RD_REQ) begin
         nxt_rdreq = 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         con_ff <= iaq_pkg::CON_RST;
         tar_ff <= iaq_pkg::TAR_RST;
         sar_ff <= iaq_pkg::SAR_RST;
         ena_ff <= 1'b0;
         abort_ff <= 1'b0;
         rdreq_ff <= 1'b0;
         rdata_ff <= 16'h0000;
         match_ff <= 1'b0;
      end else begin
         con_ff <= nxt_con;
         tar_ff <= nxt_tar;
         sar_ff <= nxt_sar;
         ena_ff <= nxt_ena;
         abort_ff <= nxt_abort;
         rdreq_ff <= nxt_rdreq;
         rdata_ff <= nxt_rdata;
         match_ff <= slave_en & addr_eq(SLV_ADDR, sar_ff,
                     con_ff[iaq_pkg::CON_TENS_BIT]);
      end
   end

   // Sequencer
   assign done = (st_ff == iaq_pkg::ST_ISSUE) & CMD_DONE;
   assign open_now = done ? ~cmd_ff[iaq_pkg::CMD_STOP_BIT] : active_ff;
   assign pop = ena_ff & master_en & q_valid & (done
                | st_ff == iaq_pkg::ST_IDLE | st_ff == iaq_pkg::ST_STALL);
   // Slave transmitter drains the queue byte by byte
   assign q_ready = pop | (~master_en & SLV_POP);
   assign turn = q_out[iaq_pkg::CMD_RESTART_BIT]
                 | (q_out[iaq_pkg::CMD_READ_BIT] != dir_ff);

   always_comb begin
      nxt_st = st_ff;
      nxt_active = active_ff;
      nxt_dir = dir_ff;
      nxt_cmd = cmd_ff;
      nxt_flag = flag_ff;
      if (pop) begin
         nxt_st = iaq_pkg::ST_ISSUE;
         nxt_active = 1'b1;
         nxt_dir = q_out[iaq_pkg::CMD_READ_BIT];
         nxt_cmd = q_out;
         // Start after stop, else restart or stop+start on a turn
         nxt_flag[0] = ~open_now;
         nxt_flag[1] = open_now & turn & ren;
         nxt_flag[2] = open_now & turn & ~ren;
         nxt_flag[3] = gc_mode;
         nxt_flag[4] = tar_ff[iaq_pkg::TAR_SPECIAL_BIT]
                       & tar_ff[iaq_pkg::TAR_SEL_BIT];
      end else begin
         unique case (st_ff)
            iaq_pkg::ST_IDLE: ;
            iaq_pkg::ST_ISSUE: begin
               if (CMD_DONE) begin
                  nxt_active = open_now;
                  // Open transfer with nothing queued stalls the bus
                  nxt_st = open_now ? iaq_pkg::ST_STALL
                           : iaq_pkg::ST_IDLE;
               end
            end
            iaq_pkg::ST_STALL: begin
               if (!ena_ff) begin
                  nxt_st = iaq_pkg::ST_IDLE;
                  nxt_active = 1'b0;
               end
            end
            default: nxt_st = iaq_pkg::ST_IDLE;
         endcase
         // Slave pop hands the head byte to the slave engine on CMD_DATA
         if (!master_en && SLV_POP && q_valid) begin
            nxt_cmd = q_out;
         end
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= iaq_pkg::ST_IDLE;
         active_ff <= 1'b0;
         dir_ff <= 1'b0;
         cmd_ff <= '0;
         flag_ff <= 5'h00;
      end else begin
         st_ff <= nxt_st;
         active_ff <= nxt_active;
         dir_ff <= nxt_dir;
         cmd_ff <= nxt_cmd;
         flag_ff <= nxt_flag;
      end
   end

   assign RDATA = rdata_ff;
   assign SCL_O = 1'b0;
   assign SCL_OE = (st_ff == iaq_pkg::ST_STALL);
   assign CMD_VALID = (st_ff == iaq_pkg::ST_ISSUE);
   assign CMD_START = flag_ff[0];
   assign CMD_RESTART = flag_ff[1];
   assign CMD_STOP_START = flag_ff[2];
   assign CMD_GCALL = flag_ff[3];
   assign CMD_SBYTE = flag_ff[4];
   assign CMD_STOP = cmd_ff[iaq_pkg::CMD_STOP_BIT];
   assign CMD_READ = cmd_ff[iaq_pkg::CMD_READ_BIT];
   assign CMD_DATA = cmd_ff[7:0];
   // Broadcast leaves the stored address out entirely
   assign CMD_TARGET = flag_ff[3] ? 10'h000 : tar_ff[9:0];
   assign SLV_MATCH = match_ff;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!rst_n);

   a_gc_read_abort: assert property (
      cmd_wr && rd_cmd && gc_mode
      |=> abort_ff && q_level <= $past(q_level))
      else $error("read after broadcast not aborted");
   a_sar_locked: assert property (
      WR && ADDR == iaq_pkg::SAR_ADDR && ena_ff |=> $stable(sar_ff))
      else $error("own address changed while enabled");
   a_gc_no_target: assert property (
      pop && gc_mode |=> CMD_GCALL && CMD_TARGET == 10'h000)
      else $error("broadcast carries target address");
   a_plain_target: assert property (
      pop && !tar_ff[iaq_pkg::TAR_SPECIAL_BIT] |=> !CMD_GCALL && !CMD_SBYTE)
      else $error("special command without special bit");
   a_forced_restart: assert property (
      pop && open_now && q_out[iaq_pkg::CMD_RESTART_BIT]
      |=> CMD_RESTART == $past(ren) && CMD_STOP_START == !$past(ren))
      else $error("restart bit not honoured");
   a_same_dir: assert property (
      pop && open_now && !turn |=> !CMD_RESTART && !CMD_STOP_START)
      else $error("needless restart");
   a_restart_permit: assert property (
      pop && !ren |=> !CMD_RESTART)
      else $error("restart while not permitted");
   a_stop_restart: assert property (
      done && cmd_ff[iaq_pkg::CMD_STOP_BIT] && pop |=> CMD_VALID && CMD_START)
      else $error("no start after stop");
   a_stall_scl: assert property (
      done && !cmd_ff[iaq_pkg::CMD_STOP_BIT] && !q_valid
      |=> SCL_OE && !SCL_O)
      else $error("bus not stalled");
   a_rdreq_abort: assert property (
      cmd_wr && rd_cmd && rdreq_ff
      |=> abort_ff && q_level <= $past(q_level))
      else $error("read after read request kept");
   c_gc_abort: cover property (cmd_wr && rd_cmd && gc_mode);
   c_restart: cover property (CMD_VALID && CMD_RESTART);
   c_stall_resume: cover property (
      st_ff == iaq_pkg::ST_STALL ##1 st_ff == iaq_pkg::ST_ISSUE);
   a_slave_data: assert property (
      !master_en && SLV_POP && q_valid |=> CMD_DATA == $past(q_out[7:0]))
      else $error("slave byte not handed over");
   c_slave_pop: cover property (!master_en && SLV_POP && q_valid);
endmodule : iaq_top
`default_nettype wire

// ### src/iaq_pkg.sv
// Package for the addressing and command queue block: register map,
// field positions, reset values and sequencer states.
// Assumes a 16-bit register port with byte addresses on a 32-bit bus.
package iaq_pkg;
   localparam logic [31:0] CON_ADDR = 32'h5000_1300;
   localparam logic [31:0] TAR_ADDR = 32'h5000_1304;
   localparam logic [31:0] SAR_ADDR = 32'h5000_1308;
   localparam logic [31:0] CMD_ADDR = 32'h5000_1310;
   localparam logic [31:0] RAW_ADDR = 32'h5000_1334;
   localparam logic [31:0] CLR_RDREQ_ADDR = 32'h5000_1350;
   localparam logic [31:0] CLR_ABORT_ADDR = 32'h5000_1354;
   localparam logic [31:0] ENA_ADDR = 32'h5000_136C;
   localparam logic [31:0] STAT_ADDR = 32'h5000_1370;
   localparam int TAR_SPECIAL_BIT = 11;
   localparam int TAR_SEL_BIT = 10;
   localparam int CMD_RESTART_BIT = 10;
   localparam int CMD_STOP_BIT = 9;
   localparam int CMD_READ_BIT = 8;
   localparam int CON_SLVDIS_BIT = 6;
   localparam int CON_RESTART_BIT = 5;
   localparam int CON_TENM_BIT = 4;
   localparam int CON_TENS_BIT = 3;
   localparam int CON_MASTER_BIT = 0;
   localparam int RAW_ABORT_BIT = 6;
   localparam int RAW_RDREQ_BIT = 5;
   localparam logic [11:0] TAR_RST = 12'h055;
   localparam logic [9:0] SAR_RST = 10'h055;
   localparam logic [6:0] CON_RST = 7'h7D;
   localparam int CMD_W = 11;
   localparam int FIFO_AW = 2;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ISSUE = 2'h1,
      ST_STALL = 2'h3
   } iaq_state_t;
endpackage : iaq_pkg

// ### src/iaq_sync.sv
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the sampled line idles high, as an open-drain bus line does.
`timescale 1ns/1ps
`default_nettype none
module iaq_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Level in and out
   input wire logic d,
   output logic q
);
   logic meta_ff;
   logic sync_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= 1'b1;
         sync_ff <= 1'b1;
      end else begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end

   assign q = sync_ff;
endmodule : iaq_sync
`default_nettype wire

// ### src/iaq_fifo.sv
// Small command queue held in flip-flops, valid/ready on both sides.
// Assumes one clock; push and pop in one cycle are both allowed.
`timescale 1ns/1ps
`default_nettype none
module iaq_fifo (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   input wire logic [iaq_pkg::CMD_W-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [iaq_pkg::CMD_W-1:0] out_data,
   input wire logic out_ready,
   // Fill level
   output logic [iaq_pkg::FIFO_AW:0] level
);
   localparam int DEPTH = 1 << iaq_pkg::FIFO_AW;
   logic [iaq_pkg::CMD_W-1:0] mem_ff [DEPTH];
   logic [iaq_pkg::FIFO_AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [iaq_pkg::FIFO_AW:0] cnt_ff, nxt_cnt;
   logic push, pop;

   assign in_ready = (cnt_ff != DEPTH[iaq_pkg::FIFO_AW:0]);
   assign out_valid = (cnt_ff != '0);
   assign out_data = mem_ff[rd_ff];
   assign level = cnt_ff;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb begin
      nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
      nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
      nxt_cnt = cnt_ff + {{iaq_pkg::FIFO_AW{1'b0}}, push}
                - {{iaq_pkg::FIFO_AW{1'b0}}, pop};
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end

   for (genvar i = 0; i < DEPTH; i++) begin : g_slot
      always_ff @(posedge clk) begin
         if (push && wr_ff == (iaq_pkg::FIFO_AW)'(i)) begin
            mem_ff[i] <= in_data;
         end
      end
   end
endmodule : iaq_fifo
`default_nettype wire

// ### test/iaq_engine_model.sv
// Far side: byte engine and bus clock source for the command queue.
// Assumes one command is offered at a time and held until done.
`timescale 1ns/1ps
`default_nettype none
module iaq_engine_model (
   // Clock
   input wire logic clk,
   // Command link
   input wire logic cmd_valid,
   output logic cmd_done,
   input wire logic slow,
   // Bus clock line
   input wire logic scl_o,
   input wire logic scl_oe,
   output logic scl_i
);
   logic scl_gen = 1'b1;
   int wait_cnt = 0;
   // One pulse per command; slow mode stretches the byte time
   always @(posedge clk) begin
      cmd_done <= 1'b0;
      if (cmd_valid && !cmd_done) begin
         if (wait_cnt == 0) begin
            cmd_done <= 1'b1;
            wait_cnt <= slow ? $urandom_range(40, 8) : 0;
         end else begin
            wait_cnt <= wait_cnt - 1;
         end
      end
   end
   // Clock runs only within frames, otherwise released to the pull-up
   always begin
      #400;
      scl_gen = cmd_valid ? !scl_gen : 1'b1;
   end
   assign scl_i = scl_gen && !(scl_oe && !scl_o);
endmodule : iaq_engine_model
`default_nettype wire

// ### test/iaq_top_tb_top.sv
// Self-checking bench for the addressing and command queue.
// Assumes the engine model answers every command it is offered.
`timescale 1ns/1ps
`default_nettype none
module iaq_top_tb_top;
   logic clk, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, slv_rd_req = 1'b0;
   logic slow = 1'b0, scl_i, scl_o, scl_oe, cmd_valid, cmd_done, slv_match;
   logic cmd_start, cmd_restart, cmd_stop_start, cmd_stop, cmd_read;
   logic cmd_gcall, cmd_sbyte;
   logic [31:0] addr = 32'h0;
   logic [15:0] wdata = 16'h0, rv, rv_q;
   logic slv_pop = 1'b0;
   logic [9:0] cmd_target, slv_addr = 10'h0, tar_m = 10'h055;
   logic [7:0] cmd_data, rx_data = 8'h00, rb;
   logic [6:0] con_m = 7'h7D;
   logic [24:0] expq[$];
   logic open_t = 1'b0, prev_rd = 1'b0, special = 1'b0, sel = 1'b0;
   int bad_count = 0, n_compared = 0, ena = 0, rdreq = 0, exp_abort = 0;
   int k, p;
   logic [6:0] ct[4] = '{7'h01, 7'h01, 7'h09, 7'h09};
   logic [9:0] at[4] = '{10'h323, 10'h124, 10'h323, 10'h123};
   logic [15:0] seq[6] = '{16'h0000, 16'h0100, 16'h0500, 16'h0200,
      16'h0100, 16'h0300};

   iaq_top i_iaq_top (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rv_q), .SCL_I(scl_i), .SCL_O(scl_o),
      .SCL_OE(scl_oe), .CMD_VALID(cmd_valid), .CMD_START(cmd_start),
      .CMD_RESTART(cmd_restart), .CMD_STOP_START(cmd_stop_start),
      .CMD_STOP(cmd_stop), .CMD_READ(cmd_read), .CMD_GCALL(cmd_gcall),
      .CMD_SBYTE(cmd_sbyte), .CMD_TARGET(cmd_target), .CMD_DATA(cmd_data),
      .CMD_DONE(cmd_done), .SLV_ADDR(slv_addr), .SLV_MATCH(slv_match),
      .SLV_RD_REQ(slv_rd_req), .SLV_POP(slv_pop), .RX_DATA(rx_data));
   iaq_engine_model i_iaq_engine_model (.clk(clk), .cmd_valid(cmd_valid),
      .cmd_done(cmd_done), .slow(slow), .scl_o(scl_o), .scl_oe(scl_oe),
      .scl_i(scl_i));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_sim

   task automatic wreg(input logic [31:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg

   task automatic rreg(input logic [31:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      rv = rv_q;
   endtask : rreg

   task automatic setcon(input logic [6:0] c);
      wreg(iaq_pkg::CON_ADDR, {9'h000, c});
      con_m = c;
   endtask : setcon

   task automatic settar(input logic [11:0] t);
      wreg(iaq_pkg::TAR_ADDR, {4'h0, t});
      special = t[11];
      sel = t[10];
      tar_m = t[9:0];
   endtask : settar

   // Reference model of queueing, refusal and condition flags
   task automatic push(input logic [15:0] w);
      logic gc, chg;
      gc = special && !sel;
      wreg(iaq_pkg::CMD_ADDR, w);
      if (ena == 0) return;
      if (w[8] && (gc || rdreq != 0 || (!con_m[6] && tar_m == 10'h123))) begin
         exp_abort = 1;
         return;
      end
      chg = open_t && (w[10] || w[8] != prev_rd);
      expq.push_back({!open_t, chg && con_m[5], chg && !con_m[5], w[9], w[8],
         gc, special && sel, gc ? 10'h000 : tar_m, w[7:0]});
      open_t = !w[9];
      prev_rd = w[8];
   endtask : push

   task automatic drain();
      for (k = 0; k < 600 && (expq.size() != 0 || cmd_valid !== 1'b0); k++)
         @(posedge clk);
      chk(expq.size(), 0);
      repeat (3) @(posedge clk);
   endtask : drain

   task automatic chk_abort();
      rreg(iaq_pkg::RAW_ADDR);
      chk(rv[6], exp_abort);
      rreg(iaq_pkg::CLR_ABORT_ADDR);
      chk(rv[0], exp_abort);
      exp_abort = 0;
   endtask : chk_abort

   always @(posedge clk) begin
      if (cmd_valid === 1'b1 && cmd_done === 1'b1) begin
         if (expq.size() == 0) chk(32'h1, 32'h0);
         else chk({cmd_start, cmd_restart, cmd_stop_start, cmd_stop, cmd_read,
            cmd_gcall, cmd_sbyte, cmd_target, cmd_data}, expq.pop_front());
      end
   end

   initial begin
      #3000000;
      bad_count++;
      end_sim();
   end

   initial begin
      void'($urandom(32'hFCCDA2D9));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rreg(iaq_pkg::TAR_ADDR);
      chk(rv, 16'h0055);
      rreg(iaq_pkg::SAR_ADDR);
      chk(rv, 16'h0055);
      wreg(32'h5000_1314, 16'hFFFF);
      rreg(32'h5000_1314);
      chk(rv, 16'h0000);
      $display("test reset done");
      wreg(iaq_pkg::ENA_ADDR, 16'h0001);
      wreg(iaq_pkg::SAR_ADDR, 16'h0123);
      rreg(iaq_pkg::SAR_ADDR);
      chk(rv, 16'h0055);
      wreg(iaq_pkg::ENA_ADDR, 16'h0000);
      wreg(iaq_pkg::SAR_ADDR, 16'h0123);
      rreg(iaq_pkg::SAR_ADDR);
      chk(rv, 16'h0123);
      // Own address 0x123: 7-bit mode looks at the low bits only
      for (p = 0; p < 4; p++) begin
         setcon(ct[p]);
         @(posedge clk);
         slv_addr <= at[p];
         @(posedge clk);
         @(negedge clk);
         chk(slv_match, p == 0 || p == 3);
      end
      push(16'h0211); // not queued while disabled
      wreg(iaq_pkg::ENA_ADDR, 16'h0001);
      ena = 1;
      $display("test own address done");
      settar(12'h123);
      push(16'h0100);
      rb = 8'($urandom);
      push({8'h02, rb});
      drain();
      chk_abort();
      $display("test self address done");
      for (p = 0; p < 2; p++) begin
         setcon(p == 0 ? 7'h5D : 7'h7D);
         slow <= p[0];
         push(seq[0]);
         drain();
         chk(scl_oe, 1'b1);
         chk(scl_o, 1'b0);
         for (int j = 1; j < 6; j++) push(seq[j] | {8'h00, 8'($urandom)});
         drain();
         chk(scl_oe, 1'b0);
      end
      $display("test sequence done");
      settar(12'h8A5);
      push(16'h0211);
      push(16'h0100);
      push(16'h0222);
      drain();
      chk_abort();
      settar(12'hCA5); // written once for the start byte
      push(16'h0233);
      settar(12'h4A5);
      push(16'h0344);
      drain();
      chk_abort();
      $display("test special done");
      @(posedge clk);
      slv_rd_req <= 1'b1;
      @(posedge clk);
      slv_rd_req <= 1'b0;
      rdreq = 1;
      rreg(iaq_pkg::RAW_ADDR);
      chk(rv[5], 1'b1);
      push(16'h0155);
      push(16'h0266);
      drain();
      chk_abort();
      rreg(iaq_pkg::CLR_RDREQ_ADDR);
      chk(rv[0], 1'b1);
      rdreq = 0;
      push(16'h0377);
      drain();
      rx_data <= 8'($urandom);
      rreg(iaq_pkg::CMD_ADDR);
      chk(rv, {8'h00, rx_data});
      $display("test read request done");
      // Slave transmitter: direction bit dropped, head byte popped
      setcon(7'h08);
      rb = 8'($urandom);
      wreg(iaq_pkg::CMD_ADDR, {8'h01, rb});
      rreg(iaq_pkg::STAT_ADDR);
      chk(rv[5:3], 3'h1);
      chk(rv[2], 1'b1);
      @(posedge clk);
      slv_pop <= 1'b1;
      @(posedge clk);
      slv_pop <= 1'b0;
      @(negedge clk);
      chk(cmd_data, rb);
      chk(cmd_read, 1'b0);
      chk(cmd_valid, 1'b0);
      rreg(iaq_pkg::STAT_ADDR);
      chk(rv[5:3], 3'h0);
      $display("test slave queue done");
      end_sim();
   end
endmodule : iaq_top_tb_top
`default_nettype wire
